// File: pll_control_registers.sv
// loop control registers, factor decode and lock model
// assumes a byte-wide register port clocked by core_clk at 40 MHz
`include "pll_ctrl_map.svh"
`default_nettype none
module pll_control_registers
	import pll_ctrl_pkg::*;
#(
	parameter int LOCK_US = `LOCK_TIME_US
) (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	output logic      [7:0]  sfr_rdata,
	input  wire logic        ext_osc_valid,
	input  wire logic [16:0] int_ref_khz,
	input  wire logic [16:0] ext_ref_khz,
	output logic             loop_bias_power,
	output logic             loop_run_enable,
	output logic             ref_source_select,
	output logic      [5:0]  predivide_factor,
	output logic      [8:0]  multiply_factor,
	output logic      [1:0]  osc_range_select,
	output logic      [3:0]  loop_filter_range,
	output logic             lock_flag,
	output logic      [16:0] divided_ref_khz,
	output logic      [25:0] loop_out_khz
);

	////////////////////////////////////////////////////////////////////
	// register state
	localparam sfr_byte_t CTL_RST = `RST_CONTROL;
	localparam sfr_byte_t DIV_RST = `RST_PREDIV;
	localparam sfr_byte_t FLT_RST = `RST_FILTER;
	logic        bias_q;
	logic        bias_d;
	logic        run_q;
	logic        run_d;
	logic        src_q;
	logic        src_d;
	logic [4:0]  prediv_q;
	logic [4:0]  prediv_d;
	logic [7:0]  mult_q;
	logic [7:0]  mult_d;
	logic [5:0]  filt_q;
	logic [5:0]  filt_d;
	sfr_byte_t   rdata_q;
	sfr_byte_t   rdata_d;
	logic        cfg_write;

	logic        wr_ctl;
	logic        wr_div;
	logic        wr_mul;
	logic        wr_flt;

	assign wr_ctl = sfr_wr && (sfr_addr == `ADDR_CONTROL);
	assign wr_div = sfr_wr && (sfr_addr == `ADDR_PREDIV);
	assign wr_mul = sfr_wr && (sfr_addr == `ADDR_MULT);
	assign wr_flt = sfr_wr && (sfr_addr == `ADDR_FILTER);

	always_comb begin
		bias_d    = bias_q;
		run_d     = run_q;
		src_d     = src_q;
		prediv_d  = prediv_q;
		mult_d    = mult_q;
		filt_d    = filt_q;
		cfg_write = 1'b0;
		if (wr_ctl) begin
			// bit 3 and bits 7-5 are not stored
			bias_d = sfr_wdata[`CTL_BIAS_BIT];
			src_d  = sfr_wdata[`CTL_SRC_BIT];
			// run may only be raised once bias is already on;
			// clearing both in one write is fine
			if (!sfr_wdata[`CTL_RUN_BIT]) begin
				run_d = 1'b0;
			end else if (bias_q) begin
				run_d = 1'b1;
			end
			if (sfr_wdata[`CTL_SRC_BIT] != src_q) begin
				cfg_write = 1'b1;
			end
		end
		if (wr_div) begin
			prediv_d  = 5'(sfr_wdata & `PREDIV_MASK);
			cfg_write = 1'b1;
		end
		if (wr_mul) begin
			mult_d    = sfr_wdata & `MULT_MASK;
			cfg_write = 1'b1;
		end
		if (wr_flt) begin
			filt_d    = 6'(sfr_wdata & `FILTER_MASK);
			cfg_write = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bias_q   <= CTL_RST[`CTL_BIAS_BIT];
			run_q    <= CTL_RST[`CTL_RUN_BIT];
			src_q    <= CTL_RST[`CTL_SRC_BIT];
			prediv_q <= DIV_RST[4:0];
			mult_q   <= `RST_MULT;
			filt_q   <= FLT_RST[5:0];
		end else begin
			bias_q   <= bias_d;
			run_q    <= run_d;
			src_q    <= src_d;
			prediv_q <= prediv_d;
			mult_q   <= mult_d;
			filt_q   <= filt_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// external reference valid, from a pin
	logic ext_valid;

	osc_valid_sync u_ext_sync (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.pin_in    (ext_osc_valid),
		.level_out (ext_valid)
	);

	////////////////////////////////////////////////////////////////////
	// lock model
	loop_state_t state_q;
	loop_state_t state_d;
	logic        loop_active;
	logic        ref_ok;
	logic        timer_run;
	logic        timer_restart;
	logic        timer_done;

	// a missing external reference keeps the loop from locking, so
	// software that skips the settle check sees no false lock
	assign ref_ok      = !src_q || ext_valid;
	assign loop_active = bias_q && run_q;

	always_comb begin
		state_d       = state_q;
		timer_restart = 1'b0;
		case (state_q)
			LOOP_OFF: begin
				if (loop_active && ref_ok) begin
					state_d       = LOOP_SETTLE;
					timer_restart = 1'b1;
				end
			end
			LOOP_SETTLE: begin
				if (!loop_active || !ref_ok) begin
					state_d = LOOP_OFF;
				end else if (cfg_write) begin
					timer_restart = 1'b1;
				end else if (timer_done) begin
					state_d = LOOP_LOCKED;
				end
			end
			LOOP_LOCKED: begin
				if (!loop_active || !ref_ok) begin
					state_d = LOOP_OFF;
				end else if (cfg_write) begin
					// retuning a running loop loses lock
					state_d       = LOOP_SETTLE;
					timer_restart = 1'b1;
				end
			end
			default: begin
				state_d = LOOP_OFF;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= LOOP_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	assign timer_run = (state_q == LOOP_SETTLE);

	lock_timer #(
		.US_CYCLES (`US_CYCLES),
		.LOCK_US   (LOCK_US)
	) u_lock_timer (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.run      (timer_run),
		.restart  (timer_restart),
		.done     (timer_done)
	);

	////////////////////////////////////////////////////////////////////
	// factor decode and frequency model
	logic [5:0]  m_d;
	logic [5:0]  m_q;
	logic [8:0]  n_d;
	logic [8:0]  n_q;
	logic [16:0] ref_khz;
	logic [16:0] dref_d;
	logic [16:0] dref_q;
	logic [25:0] fout_d;
	logic [25:0] fout_q;
	logic [25:0] prod;

	always_comb begin
		if (prediv_q == 5'h00) begin
			m_d = `PREDIV_ZERO_FACTOR;
		end else begin
			m_d = {1'b0, prediv_q};
		end
		if (mult_q == 8'h00) begin
			n_d = `MULT_ZERO_FACTOR;
		end else begin
			n_d = {1'b0, mult_q};
		end
		ref_khz = src_q ? ext_ref_khz : int_ref_khz;
		prod    = 26'(ref_khz) * 26'(n_d);
		dref_d  = ref_khz / 17'(m_d);
		// whole divide after multiply truncates only once, dropping the remainder
		fout_d  = prod / 26'(m_d);
		if (!loop_active) begin
			fout_d = 26'h0000000;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			m_q    <= 6'h01;
			n_q    <= 9'h001;
			dref_q <= 17'h00000;
			fout_q <= 26'h0000000;
		end else begin
			m_q    <= m_d;
			n_q    <= n_d;
			dref_q <= dref_d;
			fout_q <= fout_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read path
	always_comb begin
		rdata_d = rdata_q;
		if (sfr_rd) begin
			case (sfr_addr)
				`ADDR_CONTROL: begin
					rdata_d = 8'h00;
					rdata_d[`CTL_LOCK_BIT] = (state_q == LOOP_LOCKED);
					rdata_d[`CTL_SRC_BIT]  = src_q;
					rdata_d[`CTL_RUN_BIT]  = run_q;
					rdata_d[`CTL_BIAS_BIT] = bias_q;
				end
				`ADDR_PREDIV: rdata_d = {3'h0, prediv_q};
				`ADDR_MULT:   rdata_d = mult_q;
				`ADDR_FILTER: rdata_d = {2'h0, filt_q};
				default:      rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs to the analog loop
	assign sfr_rdata         = rdata_q;
	assign loop_bias_power   = bias_q;
	assign loop_run_enable   = loop_active;
	assign ref_source_select = src_q;
	assign predivide_factor  = m_q;
	assign multiply_factor   = n_q;
	assign osc_range_select  = filt_q[5:4];
	assign loop_filter_range = filt_q[3:0];
	assign lock_flag         = (state_q == LOOP_LOCKED);
	assign divided_ref_khz   = dref_q;
	assign loop_out_khz      = fout_q;

endmodule
`default_nettype wire

// File: pll_ctrl_map.svh
// register map, field positions, reset values and timing counts
// assumes the includer is compiled after this header and nothing else
`ifndef PLL_CTRL_MAP_SVH
`define PLL_CTRL_MAP_SVH

// special-function-register addresses
`define ADDR_CONTROL       8'h89
`define ADDR_PREDIV        8'h8d
`define ADDR_MULT          8'h8e
`define ADDR_FILTER        8'h8f

// control register fields
`define CTL_BIAS_BIT       0
`define CTL_RUN_BIT        1
`define CTL_SRC_BIT        2
`define CTL_LOCK_BIT       4

// writable masks, unused bits read zero
`define PREDIV_MASK        8'h1f
`define MULT_MASK          8'hff
`define FILTER_MASK        8'h3f

// reset values
`define RST_CONTROL        8'h00
`define RST_PREDIV         8'h01
`define RST_MULT           8'h01
`define RST_FILTER         8'h31

// zero-code factors
`define PREDIV_ZERO_FACTOR 6'h20
`define MULT_ZERO_FACTOR   9'h100

// timing
`define CLK_HZ             40000000
`define US_CYCLES          (`CLK_HZ / 1000000)
`define LOCK_TIME_US       202

`endif

// File: pll_ctrl_pkg.sv
// types shared by the loop control block
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package pll_ctrl_pkg;
	typedef logic [7:0] sfr_byte_t;
	typedef enum logic [1:0] {
		LOOP_OFF,
		LOOP_SETTLE,
		LOOP_LOCKED
	} loop_state_t;
endpackage
`default_nettype wire

// File: osc_valid_sync.sv
// three-stage synchroniser for the oscillator-valid pin
// assumes the pin is asynchronous to core_clk
`default_nettype none
module osc_valid_sync (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;
	logic out_d;

	// the first stage feeds only the second
	always_comb begin
		out_d = out_q;
		if (s2_q == s3_q) begin
			out_d = s3_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			out_q <= 1'b0;
		end else begin
			s1_q  <= pin_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign level_out = out_q;
endmodule
`default_nettype wire

// File: lock_timer.sv
// counts the modelled lock interval in microsecond ticks
// assumes run is a level on core_clk and restart a one-cycle pulse
`default_nettype none
module lock_timer #(
	parameter int US_CYCLES = 40,
	parameter int LOCK_US   = 202
) (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic run,
	input  wire logic restart,
	output logic      done
);
	localparam int DW = $clog2(US_CYCLES + 1);
	localparam int UW = $clog2(LOCK_US + 1);

	logic [DW-1:0] div_q;
	logic [DW-1:0] div_d;
	logic [UW-1:0] us_q;
	logic [UW-1:0] us_d;
	logic          done_q;
	logic          done_d;
	logic          tick;

	////////////////////////////////////////////////////////////////////
	// microsecond enable and interval count
	always_comb begin
		tick   = 1'b0;
		div_d  = div_q;
		us_d   = us_q;
		done_d = done_q;
		if (!run || restart) begin
			div_d  = '0;
			us_d   = '0;
			done_d = 1'b0;
		end else if (!done_q) begin
			if (div_q == DW'(US_CYCLES - 1)) begin
				div_d = '0;
				tick  = 1'b1;
			end else begin
				div_d = div_q + DW'(1);
			end
			if (tick) begin
				us_d = us_q + UW'(1);
				if (us_q == UW'(LOCK_US - 1)) begin
					done_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			div_q  <= '0;
			us_q   <= '0;
			done_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			us_q   <= us_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;
endmodule
`default_nettype wire

// File: pll_control_registers_checker.sv
// concurrent checks on the loop control block ports
// assumes it is bound to pll_control_registers, one clock domain
`default_nettype none
module pll_control_registers_checker #(
	parameter int LOCK_US = 202
) (
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       loop_bias_power,
	input wire logic       loop_run_enable,
	input wire logic       ref_source_select,
	input wire logic [5:0] predivide_factor,
	input wire logic [8:0] multiply_factor,
	input wire logic [1:0] osc_range_select,
	input wire logic [3:0] loop_filter_range,
	input wire logic       lock_flag
);
default clocking @(posedge core_clk); endclocking
default disable iff (sys_rst);
logic [15:0] run_cnt_q;
logic [15:0] run_cnt_d;
wire         cw = sfr_wr && sfr_addr == 8'h89;
////////////////////////////////////////////////////////////////////////
// cycles with run high, a lower bound for the lock rise
// saturates so a long run never wraps into a false early count
always_comb run_cnt_d = !loop_run_enable ? 16'h0 :
	(&run_cnt_q ? run_cnt_q : run_cnt_q + 16'h1);
always_ff @(posedge core_clk) run_cnt_q <= sys_rst ? 16'h0 : run_cnt_d;
////////////////////////////////////////////////////////////////////////
run_bias_a: assert property (
	loop_run_enable |-> loop_bias_power) else $error("run without bias");
run_refuse_a: assert property (
	cw && sfr_wdata[1] && !loop_bias_power |=> !loop_run_enable)
	else $error("run taken without bias");
bias_write_a: assert property (
	cw |=> loop_bias_power == $past(sfr_wdata[0]))
	else $error("bias bit wrong");
src_write_a: assert property (
	cw |=> ref_source_select == $past(sfr_wdata[2]))
	else $error("source bit wrong");
prediv_decode_a: assert property (
	sfr_wr && sfr_addr == 8'h8d |=> ##1 predivide_factor ==
	($past(sfr_wdata[4:0], 2) == 5'h00 ? 6'h20 :
	{1'b0, $past(sfr_wdata[4:0], 2)}))
	else $error("predivide factor wrong");
mult_decode_a: assert property (
	sfr_wr && sfr_addr == 8'h8e |=> ##1 multiply_factor ==
	($past(sfr_wdata, 2) == 8'h00 ? 9'h100 : {1'b0, $past(sfr_wdata, 2)}))
	else $error("multiply factor wrong");
filter_write_a: assert property (
	sfr_wr && sfr_addr == 8'h8f |=>
	{osc_range_select, loop_filter_range} == $past(sfr_wdata[5:0]))
	else $error("filter fields wrong");
unmapped_read_a: assert property (
	sfr_rd && !(sfr_addr inside {8'h89, 8'h8d, 8'h8e, 8'h8f}) |=>
	sfr_rdata == 8'h00) else $error("unmapped read not zero");
ctl_read_a: assert property (
	sfr_rd && sfr_addr == 8'h89 |=> sfr_rdata[7:5] == 3'h0 &&
	!sfr_rdata[3] && sfr_rdata[4] == $past(lock_flag))
	else $error("control readback wrong");
lock_drop_a: assert property (
	$fell(loop_run_enable) |=> !lock_flag) else $error("lock held when off");
lock_time_a: assert property (
	$rose(lock_flag) |-> run_cnt_q >= LOCK_US * 40)
	else $error("lock rose early");
endmodule
`default_nettype wire

// File: test_pll_control_registers.sv
// self-checking bench for the loop control block
// assumes the design and checker files are compiled first
`default_nettype none
module test_pll_control_registers;
timeunit 1ns;
timeprecision 100ps;
localparam int LK = 2; // short lock interval keeps the run brief
typedef struct {logic [7:0] a, d, r; logic [5:0] m; logic [8:0] f;} row_t;
logic        core_clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
logic        ext_osc_valid = 1'b1;
logic [16:0] int_ref_khz = 17'h061a8, ext_ref_khz = 17'h02710;
logic        loop_bias_power, loop_run_enable, ref_source_select, lock_flag;
logic [5:0]  predivide_factor;
logic [8:0]  multiply_factor;
logic [1:0]  osc_range_select;
logic [3:0]  loop_filter_range;
logic [16:0] divided_ref_khz;
logic [25:0] loop_out_khz;
int          bad_count = 0, cmp_count = 0, cyc = 0, n;
row_t rows [8] = '{'{8'h8d, 8'hff, 8'h1f, 6'h1f, 9'h001},
	'{8'h8d, 8'h00, 8'h00, 6'h20, 9'h001}, '{8'h8e, 8'h00, 8'h00, 6'h20, 9'h100},
	'{8'h8e, 8'hff, 8'hff, 6'h20, 9'h0ff}, '{8'h8f, 8'hff, 8'h3f, 6'h20, 9'h0ff},
	'{8'h8f, 8'h00, 8'h00, 6'h20, 9'h0ff}, '{8'h89, 8'hf7, 8'h05, 6'h20, 9'h0ff},
	'{8'h40, 8'h5a, 8'h00, 6'h20, 9'h0ff}};
pll_control_registers #(.LOCK_US(LK)) dut (.core_clk(core_clk),
	.sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
	.ext_osc_valid(ext_osc_valid), .int_ref_khz(int_ref_khz),
	.ext_ref_khz(ext_ref_khz), .loop_bias_power(loop_bias_power),
	.loop_run_enable(loop_run_enable), .ref_source_select(ref_source_select),
	.predivide_factor(predivide_factor), .multiply_factor(multiply_factor),
	.osc_range_select(osc_range_select), .loop_filter_range(loop_filter_range),
	.lock_flag(lock_flag), .divided_ref_khz(divided_ref_khz),
	.loop_out_khz(loop_out_khz));
////////////////////////////////////////////////////////////////////////
always #12.5 core_clk = ~core_clk;
always @(posedge core_clk) begin
	cyc++;
	if (cyc == 3000) begin
		bad_count++;
		wrap_up();
	end
end
task automatic chk(input logic [31:0] s, e, input string nm);
	cmp_count++;
	if (s !== e) begin
		bad_count++;
		$display("[ERR] %s expected %h seen %h", nm, e, s);
	end
endtask
task automatic wrap_up();
	$display("compares %0d mismatches %0d", cmp_count, bad_count);
	if (bad_count == 0 && cmp_count > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
task automatic wr(input logic [7:0] a, d);
	@(negedge core_clk);
	sfr_addr = a;
	sfr_wdata = d;
	sfr_wr = 1'b1;
	@(negedge core_clk);
	sfr_wr = 1'b0;
endtask
task automatic rc(input logic [7:0] a, e);
	@(negedge core_clk);
	sfr_addr = a;
	sfr_rd = 1'b1;
	@(negedge core_clk);
	sfr_rd = 1'b0;
	chk(sfr_rdata, e, "readback");
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	repeat (4) @(negedge core_clk);
	sys_rst = 1'b0;
	rc(8'h89, 8'h00);
	rc(8'h8d, 8'h01);
	rc(8'h8e, 8'h01);
	rc(8'h8f, 8'h31);
	foreach (rows[i]) begin
		wr(rows[i].a, rows[i].d); // reserved bit 3 kept zero
		rc(rows[i].a, rows[i].r);
		chk(predivide_factor, rows[i].m, "m");
		chk(multiply_factor, rows[i].f, "n");
	end
	wr(8'h89, 8'h01);
	wr(8'h8d, 8'h05); // 5 MHz divided, 100 MHz out
	wr(8'h8e, 8'h14);
	wr(8'h8f, 8'h0f);
	chk({osc_range_select, loop_filter_range}, 6'h0f, "flt");
	repeat (200) @(negedge core_clk); // 5 us settle
	chk(divided_ref_khz, 17'h01388, "div");
	chk(loop_out_khz, 26'h0, "off");
	wr(8'h89, 8'h03);
	n = 0;
	while (lock_flag !== 1'b1 && n < 400) begin
		@(negedge core_clk);
		n++;
	end
	chk(n >= LK * 40 - 2 && n <= LK * 40 + 8, 1'b1, "lock");
	chk(loop_out_khz, 26'h00186a0, "out");
	rc(8'h89, 8'h13);
	wr(8'h89, 8'h01); // sysclk already off the loop
	wr(8'h89, 8'h05); // ext ref settled before select
	chk(lock_flag, 1'b0, "unlock");
	wr(8'h8d, 8'h01); // 10 MHz divided, 50 MHz out
	wr(8'h8e, 8'h05);
	wr(8'h8f, 8'h27);
	wr(8'h89, 8'h07);
	repeat (3) @(negedge core_clk);
	chk(divided_ref_khz, 17'h02710, "ext");
	chk(loop_out_khz, 26'h000c350, "extout");
	chk(ref_source_select, 1'b1, "src");
	repeat (100) @(negedge core_clk);
	chk(lock_flag, 1'b1, "extlock");
	ext_osc_valid = 1'b0; // external reference lost
	repeat (6) @(negedge core_clk);
	chk(lock_flag, 1'b0, "extlost");
	ext_osc_valid = 1'b1;
	wr(8'h89, 8'h00); // both bits cleared at once
	rc(8'h89, 8'h00);
	chk({loop_bias_power, loop_run_enable, lock_flag}, 3'h0, "sd");
	wr(8'h89, 8'h01);
	wr(8'h8e, 8'h33);
	sys_rst = 1'b1;
	repeat (4) @(negedge core_clk);
	sys_rst = 1'b0;
	rc(8'h89, 8'h00);
	rc(8'h8e, 8'h01);
	wrap_up();
end
endmodule
bind pll_control_registers pll_control_registers_checker #(
	.LOCK_US(LOCK_US)) chk_i (.core_clk(core_clk), .sys_rst(sys_rst),
	.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .lock_flag(lock_flag),
	.loop_bias_power(loop_bias_power), .loop_run_enable(loop_run_enable),
	.ref_source_select(ref_source_select), .multiply_factor(multiply_factor),
	.predivide_factor(predivide_factor), .osc_range_select(osc_range_select),
	.loop_filter_range(loop_filter_range));
`default_nettype wire
